/* File: rtl/pcp_pkg.sv */
package pcp_pkg;
    localparam int          PCP_CNT_W          = 16;
    localparam logic [11:0] PCP_OFF_CTRL       = 12'h000;
    localparam logic [11:0] PCP_OFF_MASTER_CMP = 12'h004;
    localparam logic [11:0] PCP_OFF_SLAVE_CMP  = 12'h008;
    localparam logic [11:0] PCP_OFF_MASTER_CNT = 12'h00c;
    localparam logic [11:0] PCP_OFF_SLAVE_CNT  = 12'h010;
    localparam logic [11:0] PCP_OFF_IRQ_STAT   = 12'h014;
    localparam logic [11:0] PCP_OFF_IRQ_EN     = 12'h018;
    localparam logic [11:0] PCP_OFF_IRQ_CLR    = 12'h01c;
    localparam int          PCP_CTRL_START_BIT = 0;
    localparam int          PCP_CTRL_STOP_BIT  = 1;
    localparam int          PCP_CTRL_RUN_BIT   = 0;
    localparam int          PCP_CTRL_PAIR_LSB  = 4;
    localparam int          PCP_IRQ_PERIOD_BIT = 0;
    localparam int          PCP_IRQ_END_BIT    = 1;
    localparam logic [15:0] PCP_CMP_RST        = 16'h0000;
    localparam logic [1:0]  PCP_PAIR_RST       = 2'h0;
    typedef enum logic [1:0] {PCP_IDLE, PCP_RUN} pcp_state_t;
endpackage

/* File: rtl/pcp_chan_if.sv */
interface pcp_chan_if #(parameter int W = 16);
    logic         load;
    logic [W-1:0] load_val;
    logic         run;
    logic         zero;
    logic [W-1:0] count;
    modport ctl (output load, output load_val, output run, input zero, input count);
    modport cnt (input load, input load_val, input run, output zero, output count);
endinterface

/* File: rtl/pcp_down_counter.sv */
module pcp_down_counter #(
    parameter int W = 16
) (
    input  wire logic pclk,
    input  wire logic presetn,
    pcp_chan_if.cnt   ch
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic         is_zero;

    // hold unless running and nonzero; a load always wins
    assign is_zero    = (count_reg == '0);
    assign count_next = ch.load ? ch.load_val :
                        (ch.run && !is_zero) ? count_reg - 1'b1 : count_reg;
    assign ch.zero    = is_zero;
    assign ch.count   = count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // pcp_down_counter

/* File: rtl/pcp_pwm.sv */
// Chosen here: the placing of the registers and register access over APB.
module pcp_pwm #(
    parameter int W = pcp_pkg::PCP_CNT_W
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             master_period_irq,
    output logic [2:0]       slave_timer_output,
    output logic             irq
);
    pcp_chan_if #(.W(W)) mch ();
    pcp_chan_if #(.W(W)) sch ();

    pcp_down_counter #(.W(W)) u_master (.pclk(pclk), .presetn(presetn), .ch(mch));
    pcp_down_counter #(.W(W)) u_slave  (.pclk(pclk), .presetn(presetn), .ch(sch));

    ////////////////////////////////////////////////////////////////
    // registers
    logic [W-1:0]         master_compare_value_reg;
    logic [W-1:0]         slave_compare_value_reg;
    pcp_pkg::pcp_state_t  state_reg;
    pcp_pkg::pcp_state_t  state_next;
    logic [1:0]           pair_reg;
    logic [1:0]           irq_stat_reg;
    logic [1:0]           irq_en_reg;
    logic                 out_reg;
    logic                 out_next;
    logic                 slave_busy_reg;
    logic                 slave_full_reg;
    logic                 period_pulse_reg;
    logic [31:0]          prdata_reg;
    logic                 pready_reg;
    logic                 pslverr_reg;
    logic [2:0]           pin_reg;
    logic                 irq_reg;

    ////////////////////////////////////////////////////////////////
    // bus decode
    logic       wr_en;
    logic       rd_en;
    logic       hit_ctrl;
    logic       hit_mcmp;
    logic       hit_scmp;
    logic       hit_mcnt;
    logic       hit_scnt;
    logic       hit_stat;
    logic       hit_en;
    logic       hit_clr;
    logic       hit_any;
    logic       start_wr;
    logic       stop_wr;
    logic       running;
    logic       period_evt;
    logic       slave_done;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic [31:0] rd_mux;

    // writes commit in the access phase with pready high; reads latch prdata in the setup phase
    assign wr_en    = psel && penable && pwrite && pready_reg;
    assign rd_en    = psel && !penable && !pwrite;
    assign hit_ctrl = (paddr == pcp_pkg::PCP_OFF_CTRL);
    assign hit_mcmp = (paddr == pcp_pkg::PCP_OFF_MASTER_CMP);
    assign hit_scmp = (paddr == pcp_pkg::PCP_OFF_SLAVE_CMP);
    assign hit_mcnt = (paddr == pcp_pkg::PCP_OFF_MASTER_CNT);
    assign hit_scnt = (paddr == pcp_pkg::PCP_OFF_SLAVE_CNT);
    assign hit_stat = (paddr == pcp_pkg::PCP_OFF_IRQ_STAT);
    assign hit_en   = (paddr == pcp_pkg::PCP_OFF_IRQ_EN);
    assign hit_clr  = (paddr == pcp_pkg::PCP_OFF_IRQ_CLR);
    assign hit_any  = hit_ctrl | hit_mcmp | hit_scmp | hit_mcnt | hit_scnt
                    | hit_stat | hit_en | hit_clr;

    assign start_wr = wr_en && hit_ctrl && pwdata[pcp_pkg::PCP_CTRL_START_BIT];
    assign stop_wr  = wr_en && hit_ctrl && pwdata[pcp_pkg::PCP_CTRL_STOP_BIT];
    assign running  = (state_reg == pcp_pkg::PCP_RUN);

    always_comb begin
        if (hit_ctrl) begin
            rd_mux = {26'h0, pair_reg, 3'h0, running};
        end else if (hit_mcmp) begin
            rd_mux = {16'h0, master_compare_value_reg};
        end else if (hit_scmp) begin
            rd_mux = {16'h0, slave_compare_value_reg};
        end else if (hit_mcnt) begin
            rd_mux = {16'h0, mch.count};
        end else if (hit_scnt) begin
            rd_mux = {16'h0, sch.count};
        end else if (hit_stat) begin
            rd_mux = {30'h0, irq_stat_reg};
        end else if (hit_en) begin
            rd_mux = {30'h0, irq_en_reg};
        end else begin
            rd_mux = 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // timer sequencing
    // the start write itself is a period boundary
    assign period_evt = start_wr || (running && mch.zero);
    assign slave_done = slave_busy_reg && sch.zero && !period_evt;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pcp_pkg::PCP_IDLE: begin
                if (start_wr && !stop_wr) begin
                    state_next = pcp_pkg::PCP_RUN;
                end
            end
            pcp_pkg::PCP_RUN: begin
                if (stop_wr) begin
                    state_next = pcp_pkg::PCP_IDLE;
                end
            end
            default: state_next = pcp_pkg::PCP_IDLE;
        endcase
    end

    // compares move into counters only at a period boundary
    assign mch.load     = period_evt;
    assign mch.load_val = master_compare_value_reg;
    assign mch.run      = running;
    assign sch.load     = period_evt;
    assign sch.load_val = slave_compare_value_reg;
    assign sch.run      = running && slave_busy_reg;

    // output rises the count after the boundary, falls at slave zero
    always_comb begin
        out_next = out_reg;
        if (!running || stop_wr) begin
            out_next = 1'b0;
        end else if (period_pulse_reg) begin
            out_next = (sch.count != '0) || slave_full_reg;
        end else if (sch.zero && !slave_full_reg) begin
            out_next = 1'b0;
        end
    end

    assign irq_set = {slave_done, period_evt};
    assign irq_clr = (wr_en && hit_clr) ? pwdata[1:0] : 2'h0;

    ////////////////////////////////////////////////////////////////
    // state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg      <= pcp_pkg::PCP_IDLE;
            out_reg        <= 1'b0;
            slave_busy_reg <= 1'b0;
            slave_full_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            out_reg        <= out_next;
            slave_busy_reg <= period_evt ? 1'b1 : (slave_done ? 1'b0 : slave_busy_reg);
            // a slave value beyond the period keeps the pin high all period
            // one spare bit so a full-scale master compare cannot wrap to zero
            slave_full_reg <= period_evt ?
                ({1'b0, slave_compare_value_reg} >=
                 ({1'b0, master_compare_value_reg} + (W+1)'(1))) :
                slave_full_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_compare_value_reg <= pcp_pkg::PCP_CMP_RST;
            slave_compare_value_reg  <= pcp_pkg::PCP_CMP_RST;
            pair_reg                 <= pcp_pkg::PCP_PAIR_RST;
            irq_en_reg               <= 2'h0;
            irq_stat_reg             <= 2'h0;
        end else begin
            if (wr_en && hit_mcmp) begin
                master_compare_value_reg <= pwdata[W-1:0];
            end
            if (wr_en && hit_scmp) begin
                slave_compare_value_reg <= pwdata[W-1:0];
            end
            // pair 3 is no legal pair; 0,1,2 mean master 0,2,4
            if (wr_en && hit_ctrl && !running && pwdata[5:4] != 2'h3) begin
                pair_reg <= pwdata[5:4];
            end
            if (wr_en && hit_en) begin
                irq_en_reg <= pwdata[1:0];
            end
            // set wins over clear
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_pulse_reg    <= 1'b0;
            prdata_reg          <= 32'h0;
            pready_reg          <= 1'b0;
            pslverr_reg         <= 1'b0;
            pin_reg             <= 3'h0;
            irq_reg             <= 1'b0;
        end else begin
            period_pulse_reg    <= period_evt;
            // no wait state: pready rises in the first access cycle
            pready_reg          <= psel && !penable;
            pslverr_reg         <= psel && !penable && !hit_any;
            if (rd_en) begin
                prdata_reg <= rd_mux;
            end
            pin_reg             <= 3'h0;
            pin_reg[pair_reg]   <= out_next;
            irq_reg             <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign master_period_irq  = period_pulse_reg;
    assign slave_timer_output = pin_reg;
    assign irq                = irq_reg;
endmodule // pcp_pwm

/* File: sim/pcp_chk.sv */
module pcp_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        master_period_irq,
    input wire logic [2:0]  slave_timer_output,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pulse width assumes master compare of one or more
    property p_irq_pulse; master_period_irq |=> !master_period_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("period pulse too long");
    property p_pair; $onehot0(slave_timer_output); endproperty
    a_pair: assert property (p_pair) else $error("two pairs drive at once");
    property p_rise; $rose(|slave_timer_output) |-> $past(master_period_irq) || master_period_irq;
    endproperty
    a_rise: assert property (p_rise) else $error("output rose without period");
    property p_idle; $rose(presetn) |-> slave_timer_output == 3'h0 && !master_period_irq;
    endproperty
    a_idle: assert property (p_idle) else $error("outputs busy after reset");
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no answer in access cycle");
    property p_rdy_one; pready |=> !pready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("pready held");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_unm; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    c_irq: cover property (master_period_irq);
    c_out: cover property ($rose(|slave_timer_output));
    c_err: cover property (pready && pslverr);
endmodule // pcp_chk

bind pcp_pwm pcp_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_period_irq(master_period_irq),
    .slave_timer_output(slave_timer_output), .irq(irq));

/* File: sim/pcp_pwm_bench.sv */
module pcp_pwm_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, master_period_irq, irq, err;
    logic [2:0]  slave_timer_output, oth;
    logic [31:0] seed = 32'h18, a;
    int          fail_count = 0, check_count = 0, n, hi, m, s, k, p, cyc = 0, t0;
    int          sv[4];

    pcp_pwm dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .master_period_irq(master_period_irq),
        .slave_timer_output(slave_timer_output), .irq(irq));

    initial forever #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // the edge first, so a release and the next setup never share a time step
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            fail_count++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // counts cycles up to the next period pulse, tallying output high time meanwhile
    task automatic wait_irq(output int c);
        c = 0;
        do begin
            @(posedge pclk);
            #1;
            c++;
            hi += slave_timer_output[p];
            oth |= slave_timer_output & ~(3'h1 << p);
        end while (master_period_irq !== 1'b1 && c < 400);
        if (c >= 400) begin
            fail_count++;
            end_sim();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 7; k++) begin
            apb(1'b0, 12'(k * 4), 32'h0);
            chk(rd, 32'h0, "reset reg");
        end
        chk(32'(slave_timer_output), 32'h0, "idle out");
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(err), 32'h1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
        $display("test reset done");
        apb(1'b1, pcp_pkg::PCP_OFF_IRQ_EN, 32'h1);
        for (p = 0; p < 3; p++) begin
            seed = xs(seed);
            m = 2 + int'(seed % 8);
            seed = xs(seed);
            sv = '{0, 1 + int'(seed % 32'(m)), m + 1, m + 5};
            for (k = 0; k < 4; k++) begin
                s = sv[k];
                apb(1'b1, pcp_pkg::PCP_OFF_CTRL, 32'(p << 4));
                apb(1'b1, pcp_pkg::PCP_OFF_MASTER_CMP, 32'(m));
                apb(1'b1, pcp_pkg::PCP_OFF_SLAVE_CMP, 32'(s));
                apb(1'b0, pcp_pkg::PCP_OFF_SLAVE_CMP, 32'h0);
                chk(rd, 32'(s), "slave cmp");
                apb(1'b1, pcp_pkg::PCP_OFF_CTRL, 32'(1 | (p << 4)));
                #1;
                chk(32'(master_period_irq), 32'h1, "start pulse");
                hi = 0;
                oth = 3'h0;
                wait_irq(n);
                chk(32'(n), 32'(m + 1), "period");
                chk(32'(hi), 32'(s > m + 1 ? m + 1 : s), "duty");
                chk(32'(oth), 32'h0, "other pairs");
                chk(32'(irq), 32'h1, "irq level");
                apb(1'b1, pcp_pkg::PCP_OFF_CTRL, 32'h2);
                apb(1'b0, pcp_pkg::PCP_OFF_MASTER_CNT, 32'h0);
                a = rd;
                chk(32'(slave_timer_output), 32'h0, "stopped out");
                apb(1'b0, pcp_pkg::PCP_OFF_MASTER_CNT, 32'h0);
                chk(rd, a, "count holds");
            end
            $display("test pair %0d done", p);
        end
        // reload test: a write just after the pulse lands only at the next pulse
        p = 0;
        apb(1'b1, pcp_pkg::PCP_OFF_IRQ_CLR, 32'h3);
        apb(1'b1, pcp_pkg::PCP_OFF_IRQ_EN, 32'h0);
        apb(1'b1, pcp_pkg::PCP_OFF_MASTER_CMP, 32'd12);
        apb(1'b1, pcp_pkg::PCP_OFF_CTRL, 32'h1);
        wait_irq(n);
        t0 = cyc;
        apb(1'b1, pcp_pkg::PCP_OFF_MASTER_CMP, 32'd20);
        wait_irq(n);
        chk(32'(cyc - t0), 32'd13, "old period");
        t0 = cyc;
        wait_irq(n);
        chk(32'(cyc - t0), 32'd21, "new period");
        chk(32'(irq), 32'h0, "irq masked");
        apb(1'b1, pcp_pkg::PCP_OFF_CTRL, 32'h2);
        apb(1'b0, pcp_pkg::PCP_OFF_IRQ_STAT, 32'h0);
        chk(rd & 32'h1, 32'h1, "status sticky");
        apb(1'b1, pcp_pkg::PCP_OFF_IRQ_CLR, 32'h3);
        apb(1'b0, pcp_pkg::PCP_OFF_IRQ_STAT, 32'h0);
        chk(rd, 32'h0, "status cleared");
        $display("test reload and irq done");
        end_sim();
    end
endmodule // pcp_pwm_bench
